// ===== design/cfg_hdr_defs.svh
// What this block does
// - strap high: load subsystem ids from EEPROM
// - strap low: subsystem ids reset to zero
// - local writes update ids, not during load
// - PCI writes leave subsystem ids unchanged
// - block size code sets writable base bits
// - all-ones write reads back size mask
// - ROM register enabled only by EEPROM bit
// - ROM register writable from both buses
// - non-writable base bits ignore writes
// - capabilities pointer read-only, resets 0xDC
// - interrupt pin bit0 from EEPROM or local
// - interrupt pin bits 7..1 read zero
`ifndef CFG_HDR_DEFS_SVH
`define CFG_HDR_DEFS_SVH

`define OFF_SUBSYS 8'h2C
`define OFF_ROM_BASE 8'h30
`define OFF_CAP_PTR 8'h34
`define OFF_MISC 8'h3C
`define OFF_PMC 8'hDC

`define CAP_PTR_RESET 8'hDC
`define PMC_NEXT_PTR 8'hE4
`define PMC_CAP_ID 8'h01
`define PMC_VER_RESET 3'h1
`define BA_FULL_MASK 16'hFFFF
`define EE_ROM_EN_BIT 7

`endif

// ===== design/cfg_hdr_pkg.sv
package cfg_hdr_pkg;
	typedef logic [2:0] block_size_t;
	typedef enum logic [1:0] {
		ST_STRAP = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} load_state_t;
endpackage : cfg_hdr_pkg

// ===== design/rom_bar_mask.sv
`timescale 1ns/100ps
`include "cfg_hdr_defs.svh"
module rom_bar_mask
(
	input wire cfg_hdr_pkg::block_size_t blockSizeCode,
	output logic [15:0] writeMask
);
	import cfg_hdr_pkg::*;
	// 64 Kbytes keeps all 16 bits, each step drops one low bit
	assign writeMask = `BA_FULL_MASK << blockSizeCode;
endmodule : rom_bar_mask

// ===== design/pci_cfg_ids_rom_bar.sv
`timescale 1ns/100ps
`include "cfg_hdr_defs.svh"
module pci_cfg_ids_rom_bar
(
	input wire logic clk,
	input wire logic rst,
	input wire logic eepromStrapPin,
	output logic eepromLoadReq_r,
	input wire logic eepromDone,
	input wire logic [31:0] eepromSubsysId,
	input wire logic [7:0] eepromByte5,
	input wire logic eepromIntPin0,
	input wire cfg_hdr_pkg::block_size_t blockSizeCode,
	input wire logic pciWr,
	input wire logic pciRd,
	input wire logic [7:0] pciAddr,
	input wire logic [31:0] pciWrData,
	output logic [31:0] pciRdData_r,
	input wire logic localWr,
	input wire logic localRd,
	input wire logic [7:0] localAddr,
	input wire logic [31:0] localWrData,
	output logic [31:0] localRdData_r,
	input wire logic [31:0] pciDecodeAddr,
	output logic romHit_r
);
	import cfg_hdr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state and storage
	load_state_t st_r;
	load_state_t st_nxt;
	logic strapHigh_r;
	logic [31:0] sid_r;
	logic [31:0] sid_nxt;
	logic romEnabled_r;
	logic [15:0] ba_r;
	logic [15:0] ba_nxt;
	logic en_r;
	logic en_nxt;
	logic [7:0] maxLat_r;
	logic [7:0] minGnt_r;
	logic intPin0_r;
	logic [7:0] intLine_r;
	logic [4:0] pmeSupport_r;
	logic dsi_r;
	logic [2:0] pmVer_r;
	logic [15:0] romMask;

	rom_bar_mask u_mask
	(
		.blockSizeCode(blockSizeCode),
		.writeMask(romMask)
	);

	////////////////////////////////////////////////////////////////////////////////
	// decode
	wire running = (st_r == ST_RUN);
	wire loadDone = (st_r == ST_LOAD) && eepromDone;
	wire localWrSid = localWr && running && (localAddr == `OFF_SUBSYS);
	wire localWrRom = localWr && running && (localAddr == `OFF_ROM_BASE);
	wire pciWrRom = pciWr && running && (pciAddr == `OFF_ROM_BASE);
	wire localWrMisc = localWr && running && (localAddr == `OFF_MISC);
	wire pciWrMisc = pciWr && running && (pciAddr == `OFF_MISC);
	wire localWrPmc = localWr && running && (localAddr == `OFF_PMC);
	wire romOn = romEnabled_r && strapHigh_r;
	wire romWrAny = romOn && (localWrRom || pciWrRom);
	wire [31:0] romWrData = pciWrRom ? pciWrData : localWrData;

	wire [31:0] romWord = romOn ? {ba_r & romMask, 15'h0000, en_r} : 32'h0000_0000;
	wire [31:0] capWord = {24'h00_0000, `CAP_PTR_RESET};
	wire [31:0] miscWord = {maxLat_r, minGnt_r, 7'h00, intPin0_r, intLine_r};
	wire pmeClk = |pmeSupport_r;
	wire [31:0] pmcWord = {pmeSupport_r, 3'h0, 2'h0, dsi_r, 1'b0, pmeClk, pmVer_r,
		`PMC_NEXT_PTR, `PMC_CAP_ID};

	function automatic logic [31:0] regSelect(input logic [7:0] addr);
		case (addr)
			`OFF_SUBSYS: regSelect = sid_r;
			`OFF_ROM_BASE: regSelect = romWord;
			`OFF_CAP_PTR: regSelect = capWord;
			`OFF_MISC: regSelect = miscWord;
			`OFF_PMC: regSelect = pmcWord;
			default: regSelect = 32'h0000_0000;
		endcase
	endfunction : regSelect

	////////////////////////////////////////////////////////////////////////////////
	// strap and load sequence
	always_comb
	begin
		case (st_r)
			ST_STRAP: st_nxt = eepromStrapPin ? ST_LOAD : ST_RUN;
			ST_LOAD: st_nxt = eepromDone ? ST_RUN : ST_LOAD;
			ST_RUN: st_nxt = ST_RUN;
			default: st_nxt = ST_STRAP;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_STRAP;
			strapHigh_r <= 1'b0;
			eepromLoadReq_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			if (st_r == ST_STRAP)
				strapHigh_r <= eepromStrapPin;
			eepromLoadReq_r <= (st_nxt == ST_LOAD);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// subsystem ids: local writes only, eeprom load wins
	assign sid_nxt = loadDone ? eepromSubsysId : (localWrSid ? localWrData : sid_r);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sid_r <= 32'h0000_0000;
		else
			sid_r <= sid_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// expansion rom base, pci write wins a same-cycle collision
	assign ba_nxt = romWrAny ? ((ba_r & ~romMask) | (romWrData[31:16] & romMask)) : ba_r;
	assign en_nxt = romWrAny ? romWrData[0] : en_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			romEnabled_r <= 1'b0;
			ba_r <= 16'h0000;
			en_r <= 1'b0;
		end
		else
		begin
			if (loadDone)
				romEnabled_r <= eepromByte5[`EE_ROM_EN_BIT];
			ba_r <= ba_nxt;
			en_r <= en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// misc and power management
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			maxLat_r <= 8'h00;
			minGnt_r <= 8'h00;
			intPin0_r <= 1'b0;
			intLine_r <= 8'h00;
			pmeSupport_r <= 5'h00;
			dsi_r <= 1'b0;
			pmVer_r <= `PMC_VER_RESET;
		end
		else
		begin
			if (loadDone)
				intPin0_r <= eepromIntPin0;
			else if (localWrMisc)
			begin
				maxLat_r <= localWrData[31:24];
				minGnt_r <= localWrData[23:16];
				intPin0_r <= localWrData[8];
			end
			if (pciWrMisc)
				intLine_r <= pciWrData[7:0];
			else if (localWrMisc)
				intLine_r <= localWrData[7:0];
			if (localWrPmc)
			begin
				pmeSupport_r <= localWrData[31:27];
				dsi_r <= localWrData[21];
				pmVer_r <= localWrData[18:16];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data and rom decode
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pciRdData_r <= 32'h0000_0000;
			localRdData_r <= 32'h0000_0000;
			romHit_r <= 1'b0;
		end
		else
		begin
			if (pciRd)
				pciRdData_r <= regSelect(pciAddr);
			if (localRd)
				localRdData_r <= regSelect(localAddr);
			romHit_r <= romOn && en_r &&
				((pciDecodeAddr[31:16] & romMask) == (ba_r & romMask));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence seqStrapHigh;
		st_r == ST_STRAP && eepromStrapPin;
	endsequence

	sequence seqLoadEnd;
		st_r == ST_LOAD && eepromDone;
	endsequence

	sequence seqLoadWait;
		st_r == ST_LOAD && !eepromDone;
	endsequence

	sequence seqRomSizeWrite;
		romOn && pciWrRom && pciWrData[31:16] == `BA_FULL_MASK;
	endsequence

	sequence seqRomSizeGap;
		!romWrAny && $stable(blockSizeCode);
	endsequence

	sequence seqRomSizeRead;
		pciRd && pciAddr == `OFF_ROM_BASE && $stable(blockSizeCode);
	endsequence

	a_strap_load_entry: assert property (seqStrapHigh |=> st_r == ST_LOAD && eepromLoadReq_r)
		else $error("strap high did not start eeprom load");
	a_sid_eeprom_load: assert property (seqLoadEnd |=> sid_r == $past(eepromSubsysId)
		&& romEnabled_r == $past(eepromByte5[`EE_ROM_EN_BIT]) && st_r == ST_RUN)
		else $error("eeprom load result wrong");
	a_strap_low_zero: assert property (st_r == ST_STRAP && !eepromStrapPin
		|=> st_r == ST_RUN && sid_r == 32'h0000_0000 && !romEnabled_r)
		else $error("strap low did not leave ids zero");
	a_sid_local_write: assert property (localWrSid |=> sid_r == $past(localWrData))
		else $error("local id write lost");
	a_sid_load_block: assert property (st_r != ST_RUN && !eepromDone |=> $stable(sid_r))
		else $error("id changed outside run");
	a_sid_pci_ignore: assert property (pciWr && pciAddr == `OFF_SUBSYS && !localWrSid
		&& !loadDone |=> $stable(sid_r))
		else $error("pci write changed ids");
	a_rom_sizing: assert property (romEnabled_r && pciWrRom && pciWrData[31:16] == 16'hFFFF
		&& $stable(blockSizeCode) ##1 $stable(blockSizeCode) |-> romWord[31:16] == romMask)
		else $error("rom sizing readback wrong");
	a_rom_disabled: assert property (!romEnabled_r |-> romWord == 32'h0000_0000 && !romHit_r)
		else $error("disabled rom register not zero");
	a_rom_fixed_bits: assert property (romWrAny |=> (ba_r & ~$past(romMask))
		== ($past(ba_r) & ~$past(romMask)))
		else $error("non-writable base bit changed");
	a_cap_pointer: assert property (pciRd && pciAddr == `OFF_CAP_PTR
		|=> pciRdData_r == 32'h0000_00DC)
		else $error("capabilities pointer wrong");
	a_int_pin_high: assert property (localRd && localAddr == `OFF_MISC
		|=> localRdData_r[15:9] == 7'h00)
		else $error("interrupt pin upper bits set");
	a_rom_decode_off: assert property (!en_r |=> !romHit_r)
		else $error("rom decode while disabled");

	////////////////////////////////////////////////////////////////////////////////
	// load, strap, interrupt pin and capabilities pointer checks
	a_load_req_hold: assert property (seqLoadWait |=> st_r == ST_LOAD && eepromLoadReq_r)
		else $error("eeprom load request dropped early");
	a_load_req_drop: assert property (seqLoadEnd |=> !eepromLoadReq_r)
		else $error("eeprom load request stuck");
	a_strap_low_rom: assert property (running && !strapHigh_r |-> !romEnabled_r)
		else $error("rom register enabled without strap");
	a_int_pin_load: assert property (seqLoadEnd |=> intPin0_r == $past(eepromIntPin0))
		else $error("interrupt pin not loaded");
	a_int_pin_local: assert property (localWrMisc |=> intPin0_r == $past(localWrData[8]))
		else $error("interrupt pin local write lost");
	a_int_pin_pci: assert property (pciRd && pciAddr == `OFF_MISC
		|=> pciRdData_r[15:9] == 7'h00)
		else $error("interrupt pin upper bits set on pci read");
	a_cap_local_read: assert property (localRd && localAddr == `OFF_CAP_PTR
		|=> localRdData_r == {24'h00_0000, `CAP_PTR_RESET})
		else $error("capabilities pointer wrong on local read");

	////////////////////////////////////////////////////////////////////////////////
	// rom register checks
	a_rom_mask_width: assert property (romMask == ~((16'h0001 << blockSizeCode)
		- 16'h0001))
		else $error("rom write mask wrong for block size");
	a_rom_size_read: assert property (seqRomSizeWrite ##1 seqRomSizeGap
		##1 seqRomSizeRead |=> pciRdData_r[31:16] == $past(romMask))
		else $error("rom sizing read wrong");
	a_rom_load_block: assert property (st_r != ST_RUN |=> $stable(ba_r) && $stable(en_r))
		else $error("rom register changed outside run");
	a_rom_off_write: assert property (!romOn |=> $stable(ba_r) && $stable(en_r))
		else $error("disabled rom register written");
	a_rom_pci_write: assert property (romOn && pciWrRom |=> en_r == $past(pciWrData[0]))
		else $error("pci rom write lost");
	a_rom_local_write: assert property (romOn && localWrRom && !pciWrRom
		|=> en_r == $past(localWrData[0]))
		else $error("local rom write lost");
	a_rom_hit_base: assert property (romOn && en_r && pciDecodeAddr[31:16] == ba_r
		|=> romHit_r)
		else $error("rom decode missed its base");
endmodule : pci_cfg_ids_rom_bar

// ===== dv/eeprom_loader_model.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////
// serial eeprom loader, answers a load request after a few cycles
module eeprom_loader_model #(
	parameter logic [31:0] SUBSYS = 32'h1234_5678,
	parameter logic [7:0] BYTE5 = 8'h80
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic loadReq,
	output logic done,
	output logic [31:0] subsysId,
	output logic [7:0] byte5,
	output logic intPin
);
	int cnt;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt <= 0;
		else if (loadReq && !done)
			cnt <= cnt + 1;
		else
			cnt <= 0;
	end
	// data valid only with the done pulse
	assign done = (cnt == 5);
	assign subsysId = done ? SUBSYS : ~SUBSYS;
	assign byte5 = done ? BYTE5 : ~BYTE5;
	assign intPin = done;
endmodule : eeprom_loader_model

// ===== dv/pci_config_header_ids_rom_bar_tb.sv
`timescale 1ns/100ps
module pci_config_header_ids_rom_bar_tb;
	import cfg_hdr_pkg::*;
	logic clk = 0, rst = 1, strap = 1, loadReq, done, intPin0, romHit;
	logic pciWr = 0, pciRd = 0, localWr = 0, localRd = 0;
	logic [31:0] subsysId, pciWrData = 0, localWrData = 0, pciRdData, localRdData;
	logic [31:0] decAddr = 0;
	logic [7:0] byte5, pciAddr = 0, localAddr = 0;
	block_size_t bsc = 0;
	int errors = 0, cmp_count = 0, cyc = 0;
	//////////////////////////////////////////////////////////////////
	pci_cfg_ids_rom_bar dut_u (.clk(clk), .rst(rst), .eepromStrapPin(strap),
		.eepromLoadReq_r(loadReq), .eepromDone(done), .eepromSubsysId(subsysId),
		.eepromByte5(byte5), .eepromIntPin0(intPin0), .blockSizeCode(bsc),
		.pciWr(pciWr), .pciRd(pciRd), .pciAddr(pciAddr), .pciWrData(pciWrData),
		.pciRdData_r(pciRdData), .localWr(localWr), .localRd(localRd),
		.localAddr(localAddr), .localWrData(localWrData), .localRdData_r(localRdData),
		.pciDecodeAddr(decAddr), .romHit_r(romHit));
	eeprom_loader_model ee_u (.clk(clk), .rst(rst), .loadReq(loadReq), .done(done),
		.subsysId(subsysId), .byte5(byte5), .intPin(intPin0));
	initial forever #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			errors++;
			results();
		end
	end
	//////////////////////////////////////////////////////////////////
	task results;
		$display("compares=%0d errors=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task acc(input logic pci, input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		if (pci)
			{pciWr, pciRd, pciAddr, pciWrData} = {wr, !wr, a, d};
		else
			{localWr, localRd, localAddr, localWrData} = {wr, !wr, a, d};
		@(negedge clk);
		{pciWr, pciRd, localWr, localRd} = 4'h0;
	endtask : acc
	task rd(input logic pci, input logic [7:0] a, input logic [31:0] exp);
		acc(pci, 0, a, 0);
		chk(pci ? pciRdData : localRdData, exp);
	endtask : rd
	task boot(input logic s);
		rst = 1;
		strap = s;
		repeat (4) @(negedge clk);
		rst = 0;
		repeat (3) @(negedge clk);
		chk({31'h0, loadReq}, {31'h0, s});
		for (int i = 0; i < 50 && loadReq !== 1'b0; i++) @(negedge clk);
		chk({31'h0, loadReq}, 32'h0000_0000);
	endtask : boot
	//////////////////////////////////////////////////////////////////
	task t_load;
		boot(1);
		rd(0, 8'h2C, 32'h1234_5678);
		rd(1, 8'h34, 32'h0000_00DC);
		acc(1, 1, 8'h34, 32'hFFFF_FFFF);
		rd(1, 8'h34, 32'h0000_00DC);
		rd(0, 8'h34, 32'h0000_00DC);
		rd(1, 8'h3C, 32'h0000_0100);
		acc(0, 1, 8'h3C, 32'hFFFF_FEFF);
		rd(0, 8'h3C, 32'hFFFF_00FF);
		$display("load test done");
	endtask : t_load
	task t_sid;
		acc(1, 1, 8'h2C, 32'hAAAA_5555);
		rd(1, 8'h2C, 32'h1234_5678);
		acc(0, 1, 8'h2C, 32'hAAAA_5555);
		rd(1, 8'h2C, 32'hAAAA_5555);
		$display("ids test done");
	endtask : t_sid
	task t_rom;
		for (int b = 0; b < 8; b++)
		begin
			bsc = b[2:0];
			acc(1, 1, 8'h30, 32'hFFFF_FFFF);
			rd(1, 8'h30, (32'hFFFF_0000 << b) | 32'h0000_0001);
		end
		acc(1, 1, 8'h30, 32'h0000_0000);
		bsc = 3'h0;
		rd(1, 8'h30, 32'h007F_0000);
		acc(0, 1, 8'h30, 32'h0001_0001);
		rd(0, 8'h30, 32'h0001_0001);
		decAddr = 32'h0001_2345;
		repeat (2) @(negedge clk);
		chk({31'h0, romHit}, 32'h0000_0001);
		acc(0, 1, 8'h30, 32'h0001_0000);
		repeat (2) @(negedge clk);
		chk({31'h0, romHit}, 32'h0000_0000);
		$display("rom test done");
	endtask : t_rom
	task t_nostrap;
		boot(0);
		rd(0, 8'h2C, 32'h0000_0000);
		acc(1, 1, 8'h30, 32'hFFFF_FFFF);
		rd(1, 8'h30, 32'h0000_0000);
		acc(1, 1, 8'h3C, 32'hFFFF_FF0B);
		rd(0, 8'h3C, 32'h0000_000B);
		$display("strap low test done");
	endtask : t_nostrap
	initial
	begin
		t_load();
		t_sid();
		t_rom();
		t_nostrap();
		results();
	end
endmodule : pci_config_header_ids_rom_bar_tb
